// *** hdl/adcpc_pkg.sv ***
package adcpc_pkg;

  localparam int NUM_CH = 4;
  localparam int DATA_W = 12;
  localparam int CLK_MHZ = 100;

  // Wake-up after pin power-down, in microseconds
  localparam int WAKE_US = 375;
  localparam int WAKE_CYC = WAKE_US * CLK_MHZ;
  localparam int WAKE_W = 16;

  // Wake-up from standby, in nanoseconds (longest time rounds down)
  localparam int STBY_NS = 600;
  localparam int STBY_CYC = (STBY_NS * CLK_MHZ) / 1000;

  // Lowest sample rate at which the stabilizer loop runs
  localparam int STAB_MIN_MHZ = 20;
  localparam int STAB_MAX_PER = CLK_MHZ / STAB_MIN_MHZ;

  // Relock bypass, held for the longest relock time
  localparam int RELOCK_US = 5;
  localparam int RELOCK_CYC = RELOCK_US * CLK_MHZ;
  localparam int RELOCK_W = 10;
  localparam int PER_W = 8;

  typedef logic [NUM_CH-1:0][DATA_W-1:0] adcpc_samples_t;

  // Configuration word captured on a write strobe
  typedef struct packed {
    logic [NUM_CH-1:0] chan_pd;
    logic standby;
    logic stab_en;
    logic low_swing;
    logic term_boost;
    logic twos;
  } adcpc_cfg_t;

  // Stabilizer enabled at power-up, everything else off
  localparam adcpc_cfg_t CFG_RESET = '{chan_pd: 4'h0, standby: 1'b0, stab_en: 1'b1,
                                       low_swing: 1'b0, term_boost: 1'b0, twos: 1'b0};

endpackage

// *** hdl/adcpc_coder.sv ***
`timescale 1ns/1ps
module adcpc_coder
  import adcpc_pkg::*;
(
  input wire logic twos_in,
  input wire adcpc_samples_t raw_in,
  output adcpc_samples_t coded_out
);

  // Raw words are offset binary already; twos complement only flips the MSB
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      assign coded_out[ch] = {raw_in[ch][DATA_W-1] ^ twos_in,
                              raw_in[ch][DATA_W-2:0]};
    end
  endgenerate

endmodule // adcpc_coder

// *** hdl/adcpc_ctrl.sv ***
`timescale 1ns/1ps
module adcpc_ctrl
  import adcpc_pkg::*;
#(
  parameter int WAKE_CYC_P = WAKE_CYC
) (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic POWER_DOWN_PIN_IN,
  input wire logic OUTPUT_MODE_PIN_IN,
  input wire logic CFG_WE_IN,
  input wire adcpc_cfg_t CFG_IN,
  input wire logic SAMPLE_VALID_IN,
  input wire adcpc_samples_t SAMPLE_IN,
  output adcpc_cfg_t CFG_OUT,
  output adcpc_samples_t DATA_OUT,
  output logic DATA_VALID_OUT,
  output logic [NUM_CH-1:0] DRV_OE_OUT,
  output logic [NUM_CH-1:0] TERM_BOOST_OUT,
  output logic LOW_SWING_OUT,
  output logic PLL_ON_OUT,
  output logic READY_OUT,
  output logic STAB_ON_OUT
);

  typedef struct packed {
    logic pd_s1;
    logic pd_s2;
    logic pd_prev;
    logic mode_s1;
    logic mode_s2;
    logic stby_prev;
    adcpc_cfg_t cfg;
    logic [WAKE_W-1:0] pd_len;
    logic [WAKE_W-1:0] wake_cnt;
    logic [PER_W-1:0] per_cnt;
    logic [PER_W-1:0] last_per;
    logic per_valid;
    logic [RELOCK_W-1:0] relock_cnt;
    adcpc_samples_t data;
    logic dvalid;
    logic [NUM_CH-1:0] oe;
    logic [NUM_CH-1:0] term;
    logic low_swing;
    logic pll_on;
    logic ready;
    logic stab_on;
  } adcpc_state_t;

  localparam logic [WAKE_W-1:0] WAKE_FULL = WAKE_W'(WAKE_CYC_P);
  localparam logic [WAKE_W-1:0] WAKE_STBY = WAKE_W'(STBY_CYC);
  localparam logic [RELOCK_W-1:0] RELOCK_LOAD = RELOCK_W'(RELOCK_CYC);
  localparam logic [PER_W-1:0] PER_LIMIT = PER_W'(STAB_MAX_PER);
  localparam logic [PER_W-1:0] PER_MAX = '1;

  adcpc_state_t state_reg;
  adcpc_state_t state_next;
  adcpc_samples_t coded;
  logic pd;
  logic awake;

  adcpc_coder u_coder (
    .twos_in(state_reg.cfg.twos),
    .raw_in(SAMPLE_IN),
    .coded_out(coded)
  );

  assign pd = state_reg.pd_s2;
  // Release cycles count as asleep, else ready blinks before the wake timer loads
  assign awake = !pd && !state_reg.cfg.standby && !state_reg.pd_prev &&
                 !state_reg.stby_prev && (state_reg.wake_cnt == '0);

  // Next-state logic for the whole block
  always_comb begin
    state_next = state_reg;
    // Pins come from outside the clock domain
    state_next.pd_s1 = POWER_DOWN_PIN_IN;
    state_next.pd_s2 = state_reg.pd_s1;
    state_next.mode_s1 = OUTPUT_MODE_PIN_IN;
    state_next.mode_s2 = state_reg.mode_s1;
    state_next.pd_prev = pd;
    state_next.stby_prev = state_reg.cfg.standby;

    // Configuration is never cleared by power-down, so it survives it
    if (CFG_WE_IN) begin
      state_next.cfg = CFG_IN;
    end

    // Wake timer: downtime is measured so a short power-down wakes sooner
    if (pd) begin
      state_next.wake_cnt = '0;
      if (state_reg.pd_len != WAKE_FULL) begin
        state_next.pd_len = state_reg.pd_len + 1'b1;
      end
    end else if (state_reg.pd_prev) begin
      state_next.wake_cnt = (state_reg.pd_len < WAKE_FULL) ? state_reg.pd_len
                                                           : WAKE_FULL;
      state_next.pd_len = '0;
    end else if (state_reg.stby_prev && !state_reg.cfg.standby &&
                 state_reg.wake_cnt < WAKE_STBY) begin
      state_next.wake_cnt = WAKE_STBY;
    end else if (state_reg.wake_cnt != '0 && !state_reg.cfg.standby) begin
      state_next.wake_cnt = state_reg.wake_cnt - 1'b1;
    end

    // Sample period measured between strobes, in clock cycles
    if (state_reg.per_cnt != PER_MAX) begin
      state_next.per_cnt = state_reg.per_cnt + 1'b1;
    end
    if (state_reg.relock_cnt != '0) begin
      state_next.relock_cnt = state_reg.relock_cnt - 1'b1;
    end
    if (SAMPLE_VALID_IN) begin
      state_next.per_cnt = PER_W'(1);
      state_next.last_per = state_reg.per_cnt;
      state_next.per_valid = 1'b1;
      // Any rate change forces a full relock bypass
      if (state_reg.per_valid && state_reg.per_cnt != state_reg.last_per) begin
        state_next.relock_cnt = RELOCK_LOAD;
      end
    end

    // Internal clock is retimed only while the loop is enabled and locked;
    // next-cycle period and relock values drop the loop on the very strobe of a change
    state_next.stab_on = state_reg.cfg.stab_en && state_next.per_valid && !pd &&
                         (state_next.last_per <= PER_LIMIT) &&
                         (state_next.relock_cnt == '0);

    // Drivers released in power-down or when their channel is off
    state_next.oe = pd ? '0 : ~state_reg.cfg.chan_pd;
    state_next.pll_on = !pd;
    state_next.ready = awake;
    state_next.low_swing = state_reg.cfg.low_swing | state_reg.mode_s2;
    state_next.term = {NUM_CH{state_reg.cfg.term_boost}};

    // Data path holds the last word of a channel that is off
    state_next.dvalid = SAMPLE_VALID_IN && awake;
    for (int ch = 0; ch < NUM_CH; ch++) begin
      if (SAMPLE_VALID_IN && awake && !state_reg.cfg.chan_pd[ch]) begin
        state_next.data[ch] = coded[ch];
      end
    end
  end

  // State register; power-up values give standard swing and offset binary
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      state_reg <= '0;
      state_reg.cfg <= CFG_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign CFG_OUT = state_reg.cfg;
  assign DATA_OUT = state_reg.data;
  assign DATA_VALID_OUT = state_reg.dvalid;
  assign DRV_OE_OUT = state_reg.oe;
  assign TERM_BOOST_OUT = state_reg.term;
  assign LOW_SWING_OUT = state_reg.low_swing;
  assign PLL_ON_OUT = state_reg.pll_on;
  assign READY_OUT = state_reg.ready;
  assign STAB_ON_OUT = state_reg.stab_on;

  // Checks and coverage
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  localparam int STBY_LIM = STBY_CYC + 2;

  chk_pd_hiz_drivers: assert property (
    pd |=> (DRV_OE_OUT == '0) && !READY_OUT)
    else $error("drivers enabled during power-down");
  chk_pd_pll_off: assert property (
    pd ##1 pd |-> !PLL_ON_OUT && !STAB_ON_OUT)
    else $error("PLL left on in power-down");
  chk_cfg_retained: assert property (
    !CFG_WE_IN |=> state_reg.cfg == $past(state_reg.cfg))
    else $error("configuration changed without a write");
  chk_chan_pd_lane: assert property (
    !pd && state_reg.cfg.chan_pd[1] |=> !DRV_OE_OUT[1] && $stable(DATA_OUT[1]))
    else $error("powered-down channel still active");
  chk_stby_wake: assert property (
    $fell(state_reg.cfg.standby) && !pd && !CFG_WE_IN && state_reg.wake_cnt == '0
      && !state_reg.pd_prev ##1 !state_reg.cfg.standby[*2]
    |-> !READY_OUT ##[1:STBY_LIM] READY_OUT)
    else $error("standby wake-up time wrong");
  chk_stby_pll_on: assert property (
    state_reg.cfg.standby && !pd |=> PLL_ON_OUT && !READY_OUT)
    else $error("standby dropped PLL or stayed ready");
  chk_pd_wake_quiet: assert property (
    $fell(pd) |-> !READY_OUT [*3])
    else $error("ready blinked on power-down release");
  chk_stby_wake_quiet: assert property (
    $fell(state_reg.cfg.standby) |-> !READY_OUT [*3])
    else $error("ready blinked on standby release");
  chk_stab_slow_clock: assert property (
    state_reg.last_per > PER_LIMIT |=> !STAB_ON_OUT)
    else $error("stabilizer on below its lowest rate");
  chk_stab_relock_bypass: assert property (
    SAMPLE_VALID_IN && state_reg.per_valid && state_reg.per_cnt != state_reg.last_per
    |=> !STAB_ON_OUT [*3])
    else $error("stabilizer not bypassed after rate change");
  chk_swing_default: assert property (
    !state_reg.cfg.low_swing && !state_reg.mode_s2 |=> !LOW_SWING_OUT)
    else $error("reduced swing without request");
  chk_term_all_four: assert property (
    state_reg.cfg.term_boost |=> TERM_BOOST_OUT == '1)
    else $error("termination boost not on all outputs");
  chk_code_format: assert property (
    SAMPLE_VALID_IN && awake && !state_reg.cfg.chan_pd[0]
    |=> DATA_OUT[0] == ($past(SAMPLE_IN[0]) ^
        {$past(state_reg.cfg.twos), {(DATA_W-1){1'b0}}}))
    else $error("output coding wrong");

  cov_pd_cycle: cover property (pd ##1 !pd ##[1:300] READY_OUT);
  cov_relock: cover property (state_reg.relock_cnt == RELOCK_LOAD);
  cov_twos_sample: cover property (DATA_VALID_OUT && state_reg.cfg.twos);
  cov_stab_locked: cover property (STAB_ON_OUT);

endmodule // adcpc_ctrl

// *** test/adcpc_rx_model.sv ***
`timescale 1ns/1ps
module adcpc_rx_model
  import adcpc_pkg::*;
(
  input wire logic clk_in,
  input wire logic [NUM_CH-1:0] oe_in,
  input wire logic valid_in,
  input wire adcpc_samples_t data_in,
  output adcpc_samples_t seen_out,
  output logic [NUM_CH-1:0] live_out
);
  // Undriven lanes float with no bias, so show a changing level, not the last word
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < NUM_CH; i++) begin
      live_out[i] <= oe_in[i];
      if (!oe_in[i]) seen_out[i] <= ~seen_out[i];
      else if (valid_in) seen_out[i] <= data_in[i];
    end
  end
endmodule // adcpc_rx_model

// *** test/test_adc_power_and_output_control.sv ***
`timescale 1ns/1ps
module test_adc_power_and_output_control
  import adcpc_pkg::*;
;
  localparam int WAKE_P = 200;
  logic clk = 0, rst_n = 0, pd_pin = 0, mode_pin = 0, we = 0, sv = 0;
  adcpc_cfg_t cfg_in = CFG_RESET, cur = CFG_RESET, cfg_o;
  adcpc_samples_t smp = '0, held = '0, dat, seen;
  adcpc_samples_t expq[$];
  logic dv, low_sw, pll, rdy, stab;
  logic [NUM_CH-1:0] oe, term, live;
  int mismatches = 0, compares = 0;
  int unsigned rng = 80604;

  // Bench clock, 10 ns period
  always #5 clk = ~clk;

  adcpc_ctrl #(.WAKE_CYC_P(WAKE_P)) uut (.CLK_IN(clk), .RST_N_IN(rst_n),
    .POWER_DOWN_PIN_IN(pd_pin), .OUTPUT_MODE_PIN_IN(mode_pin), .CFG_WE_IN(we),
    .CFG_IN(cfg_in), .SAMPLE_VALID_IN(sv), .SAMPLE_IN(smp), .CFG_OUT(cfg_o),
    .DATA_OUT(dat), .DATA_VALID_OUT(dv), .DRV_OE_OUT(oe), .TERM_BOOST_OUT(term),
    .LOW_SWING_OUT(low_sw), .PLL_ON_OUT(pll), .READY_OUT(rdy), .STAB_ON_OUT(stab));
  adcpc_rx_model rx (.clk_in(clk), .oe_in(oe), .valid_in(dv), .data_in(dat),
    .seen_out(seen), .live_out(live));

  // Comparison, verdict and stimulus helpers
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic int unsigned xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic write_cfg(input adcpc_cfg_t c);
    cfg_in = c;
    cur = c;
    we = 1;
    tick(1);
    we = 0;
    tick(2);
  endtask
  // Integer model: twos complement is the offset code shifted by half scale
  task automatic send(input adcpc_samples_t s);
    adcpc_samples_t e;
    for (int i = 0; i < NUM_CH; i++) begin
      e[i] = cur.chan_pd[i] ? held[i] : 12'((int'(s[i]) + (cur.twos ? 2048 : 0)) % 4096);
    end
    expq.push_back(e);
    smp = s;
    sv = 1;
    tick(1);
    sv = 0;
    // Valid stands one cycle only, so it is looked at right after the taking edge
    chk(48'(dv), 48'(1));
    chk(dat, expq.pop_front());
    held = e;
    tick(1);
    for (int i = 0; i < NUM_CH; i++) begin
      if (!cur.chan_pd[i]) chk(48'(seen[i]), 48'(e[i]));
    end
    tick(1);
  endtask
  // Strobes at a fixed spacing; the spacing stands for the sample rate
  task automatic burst(input int n, input int gap);
    repeat (n) begin
      send(48'({xs(), xs()}));
      tick(gap - 3);
    end
  endtask
  task automatic wait_rdy(input int lim);
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < lim) begin
      tick(1);
      n++;
    end
    chk(48'(rdy), 48'(1));
  endtask

  // Main sequence
  initial begin
    tick(20);
    rst_n = 1;
    tick(2);
    chk(48'(cfg_o), 48'(CFG_RESET));
    chk(48'({low_sw, term, oe, pll, rdy}), 48'({1'b0, 4'h0, 4'hf, 2'b11}));
    $display("end of reset test");
    for (int t = 0; t < 2; t++) begin
      cur.twos = t[0];
      write_cfg(cur);
      send({12'hfff, 12'h800, 12'h7ff, 12'h000});
      burst(20, 3);
    end
    $display("end of coding test");
    cur.term_boost = 1;
    write_cfg(cur);
    chk(48'(term), 48'(4'hf));
    mode_pin = 1;
    tick(4);
    chk(48'(low_sw), 48'(1));
    mode_pin = 0;
    cur.low_swing = 1;
    write_cfg(cur);
    chk(48'(low_sw), 48'(1));
    cur.chan_pd = 4'h2;
    write_cfg(cur);
    chk(48'(oe), 48'(4'hd));
    burst(4, 3);
    $display("end of option test");
    cur.standby = 1;
    write_cfg(cur);
    chk(48'({pll, rdy}), 48'(2'b10));
    // Standby released by hand so the cycles right after the write are watched too
    cur.standby = 0;
    cfg_in = cur;
    we = 1;
    tick(1);
    we = 0;
    repeat (3) begin
      tick(1);
      chk(48'(rdy), 48'(0));
    end
    wait_rdy(70);
    $display("end of standby test");
    pd_pin = 1;
    tick(4);
    chk(48'({oe, live, pll, rdy, stab}), 48'(0));
    chk(48'(cfg_o), 48'(cur));
    tick(300);
    pd_pin = 0;
    repeat (3) begin
      tick(1);
      chk(48'(rdy), 48'(0));
    end
    tick(1);
    chk(48'({oe, pll, rdy}), 48'({4'hd, 2'b10}));
    wait_rdy(WAKE_P + 20);
    burst(3, 3);
    $display("end of power-down test");
    burst(130, 5);
    chk(48'(stab), 48'(1));
    // Long enough for the relock bypass to run out, so only the slow rate keeps it off
    burst(110, 6);
    chk(48'(stab), 48'(0));
    burst(50, 5);
    chk(48'(stab), 48'(0));
    burst(60, 5);
    chk(48'(stab), 48'(1));
    cur.stab_en = 0;
    write_cfg(cur);
    chk(48'(stab), 48'(0));
    burst(4, 5);
    chk(48'(stab), 48'(0));
    $display("end of stabilizer test");
    give_verdict();
  end

  // Watchdog sized well past the expected few thousand cycles
  initial begin
    tick(20000);
    mismatches++;
    give_verdict();
  end
endmodule // test_adc_power_and_output_control
